// ===== core/spm_pkg.sv
package spm_pkg;
    // Register indices reached through the index/data pair, and the PM logical device number
    localparam logic [7:0] IDX_WAKE_EN1 = 8'hb0;
    localparam logic [7:0] IDX_WAKE_EN2 = 8'hb1;
    localparam logic [7:0] IDX_WAKE_ST1 = 8'hb2;
    localparam logic [7:0] IDX_WAKE_ST2 = 8'hb3;
    localparam logic [7:0] IDX_SMI_EN1 = 8'hb4;
    localparam logic [7:0] IDX_SMI_EN2 = 8'hb5;
    localparam logic [7:0] IDX_SMI_ST1 = 8'hb6;
    localparam logic [7:0] IDX_SMI_ST2 = 8'hb7;
    localparam logic [7:0] IDX_DELAY2 = 8'hb8;
    localparam logic [7:0] IDX_SOFT_OFF = 8'hf4;
    localparam logic [7:0] PM_LDN = 8'h08;

    // Field positions
    localparam int OFF_EN_BIT = 7;
    localparam int SOFTWARE_POWER_OFF_BIT = 7;
    localparam int RESTART_BIT = 6;
    localparam int STOP_BIT = 5;
    localparam int SMI_GATE_BIT = 7;
    localparam int WDT_LOW_W = 5;

    // Reset values and Delay-2 limit
    localparam logic [7:0] WAKE_EN1_RST = 8'h00;
    localparam logic [7:0] WAKE_EN2_RST = 8'h80;
    localparam logic [7:0] SMI_EN_RST = 8'h00;
    localparam logic [7:0] DELAY2_RST = 8'h00;
    localparam logic [5:0] DELAY2_MAX = 6'h3f;

    // Counts
    localparam int NUM_WAKE = 15;
    localparam int NUM_SMI = 13;
    localparam int CLK_NS = 20;
    localparam int SLOW_PERIOD_NS = 31250;
    localparam int SLOW_TICK_CYC = SLOW_PERIOD_NS / CLK_NS;
    localparam int HALF_SEC_MS = 500;
    localparam int OVERRIDE_MS = 4000;
    localparam int OVERRIDE_STEPS = OVERRIDE_MS / HALF_SEC_MS;

    typedef struct packed {
        logic idx_wr;
        logic data_wr;
        logic data_rd;
        logic [7:0] wdata;
    } spm_cfg_s;
endpackage

// ===== core/spm_soft_power.sv
`timescale 1ns/1ps
// Overview of operation
// - Button or enabled wake edge powers on
// - Trickle return powers on per alarm/POR bits
// - Button powers off after Delay-2 time
// - Button power-off enable resets to one
// - Soft-off register bit 7 write powers off
// - Bits 7:5 are power-off, restart, stop
// - Status always set; only enabled wake
// - Delay-2 spans 500 ms to 32 s
// - Four-second hold forces power off
// - Override works only when enabled
// - Override sets status, clears button status
// - Override status clears on write one
// - Override timer counts held, clears released
// - Half-second steps, trigger 4 to 4.5 s
// - Timer expiry pulse clears power latch
// - Power latch keeps last on/off state
// - Group SMI ORs enabled source requests
// - SMI pin gated by enable-2 bit 7
// - Registers via config LDN 8 or index/data
// - Alarm-2 remember wakes after outage
// - Trickle POR wake enable starts machine
module spm_soft_power
    import spm_pkg::*;
#(
    parameter int HALF_SEC_TICKS = 16000
) (
    input wire logic CLK, // 50 MHz clock
    input wire logic RST_N, // Synchronous reset
    input wire spm_pkg::spm_cfg_s CFG, // Index/data access
    input wire logic CFG_MODE, // Configuration mode active
    input wire logic [7:0] CFG_LDN, // Selected logical device
    output logic [7:0] CFG_RDATA, // Data port read value
    input wire logic BTN, // Power button pin
    input wire logic [spm_pkg::NUM_WAKE-1:0] WAKE_SRC, // Wake pins
    input wire logic TRICKLE_POR, // Trickle supply came back
    input wire logic ALARM2_PASSED, // Alarm 2 matured in outage
    input wire logic ALARM2_REMEMBER_EN, // Battery-backed bit
    input wire logic TRICKLE_POR_WAKE_EN, // Battery-backed bit
    input wire logic OVERRIDE_ENABLE, // Override function on
    input wire logic OVERRIDE_STATUS_CLR, // Write-one clear pulse
    input wire logic BUTTON_STATUS_CLR, // Button status clear
    input wire logic [spm_pkg::NUM_SMI-1:0] SMI_REQ, // Unit requests
    output logic OVERRIDE_STATUS, // Override happened
    output logic BUTTON_PRESS_STATUS, // Button pressed
    output logic POWER_ON_N, // Main supply on, low
    output logic MGMT_IRQ_N, // Group SMI pin, low
    output logic WDT_RESTART, // Restart count pulse
    output logic WDT_STOP // Stop count pulse
);
    import spm_pkg::*;

    if (HALF_SEC_TICKS < 1 || HALF_SEC_TICKS > 65535) begin : g_tick_chk
        $error("HALF_SEC_TICKS out of range");
    end

    localparam int SW = NUM_WAKE + 2;
    // Idle levels: supply up, button released, wake pins high
    localparam logic [SW-1:0] PIN_IDLE = {1'b1, 1'b0, {NUM_WAKE{1'b1}}};

    // Pin synchronisers
    logic [SW-1:0] pin_s1_reg;
    logic [SW-1:0] pin_s2_reg;
    logic [SW-1:0] pin_q_reg;
    logic [SW-1:0] pin_q_next;
    logic [SW-1:0] pin_fall;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_s1_reg <= PIN_IDLE;
            pin_s2_reg <= PIN_IDLE;
        end else begin
            pin_s1_reg <= {TRICKLE_POR, BTN, WAKE_SRC};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic [10:0] div_reg, div_next;
    logic tick;
    logic [15:0] half_reg, half_next;
    logic [3:0] ovr_reg, ovr_next;
    logic [5:0] dly_reg, dly_next;
    logic dly_run_reg, dly_run_next;
    logic [15:0] dhalf_reg, dhalf_next;
    logic on_reg, on_next;
    logic ovr_sts_reg, ovr_sts_next;
    logic btn_sts_reg, btn_sts_next;
    logic [7:0] idx_reg, idx_next;
    logic [7:0] wen1_reg, wen1_next;
    logic [7:0] wen2_reg, wen2_next;
    logic [NUM_WAKE-1:0] wst_reg, wst_next;
    logic [7:0] sen1_reg, sen1_next;
    logic [7:0] sen2_reg, sen2_next;
    logic [NUM_SMI-1:0] sst_reg, sst_next;
    logic [5:0] d2_reg, d2_next;
    logic [WDT_LOW_W-1:0] wdt_reg, wdt_next;
    logic restart_reg, restart_next;
    logic stop_reg, stop_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_n_reg, irq_n_next;

    logic sel;
    logic wr;
    logic rd;
    logic btn_fall;
    logic por_rise;
    logic [NUM_WAKE-1:0] wake_fall;
    logic [NUM_WAKE-1:0] wake_en;
    logic [NUM_SMI-1:0] smi_en;
    logic ovr_fire;
    logic btn_off;
    logic power_up;
    logic power_down;
    logic [7:0] rd_val;

    assign tick = (div_reg == 11'(SLOW_TICK_CYC - 1));
    assign sel = !CFG_MODE || (CFG_LDN == PM_LDN);
    assign wr = CFG.data_wr && sel;
    assign rd = CFG.data_rd && sel;
    assign btn_fall = pin_fall[NUM_WAKE];
    assign wake_fall = pin_fall[NUM_WAKE-1:0];
    assign wake_en = {wen2_reg[NUM_WAKE-9:0], wen1_reg};
    assign smi_en = {sen2_reg[NUM_SMI-9:0], sen1_reg};

    // Edges seen only at slow-clock sampling points
    always_comb begin
        pin_q_next = pin_q_reg;
        pin_fall = '0;
        if (tick) begin
            pin_q_next = pin_s2_reg;
            pin_fall = pin_q_reg & ~pin_s2_reg;
        end
    end

    // Trickle return is a rising edge of its flag
    assign por_rise = tick && !pin_q_reg[SW-1] && pin_s2_reg[SW-1];

    // Override timer fires once after eight half-second steps
    assign ovr_fire = tick && pin_q_reg[NUM_WAKE] && OVERRIDE_ENABLE
        && (half_reg == 16'(HALF_SEC_TICKS - 1))
        && (ovr_reg == 4'(OVERRIDE_STEPS - 1)) && on_reg;

    assign btn_off = dly_run_reg && tick && (dly_reg == d2_reg)
        && (dhalf_reg == 16'(HALF_SEC_TICKS - 1));
    assign power_down = ovr_fire || btn_off
        || (wr && idx_reg == IDX_SOFT_OFF && CFG.wdata[SOFTWARE_POWER_OFF_BIT]);
    assign power_up = btn_fall && !on_reg
        || (|(wake_fall & wake_en))
        || (por_rise && (TRICKLE_POR_WAKE_EN
        || (ALARM2_REMEMBER_EN && ALARM2_PASSED)));

    always_comb begin
        case (idx_reg)
            IDX_WAKE_EN1: rd_val = wen1_reg;
            IDX_WAKE_EN2: rd_val = wen2_reg;
            IDX_WAKE_ST1: rd_val = wst_reg[7:0];
            IDX_WAKE_ST2: rd_val = {1'b0, wst_reg[NUM_WAKE-1:8]};
            IDX_SMI_EN1: rd_val = sen1_reg;
            IDX_SMI_EN2: rd_val = sen2_reg;
            IDX_SMI_ST1: rd_val = sst_reg[7:0];
            IDX_SMI_ST2: rd_val = {3'h0, sst_reg[NUM_SMI-1:8]};
            IDX_DELAY2: rd_val = {2'h0, d2_reg};
            IDX_SOFT_OFF: rd_val = {3'h0, wdt_reg};
            default: rd_val = 8'h00;
        endcase
    end

    always_comb begin
        div_next = tick ? 11'h000 : div_reg + 11'h001;
        idx_next = CFG.idx_wr ? CFG.wdata : idx_reg;
        rdata_next = rd ? rd_val : rdata_reg;
        wen1_next = wen1_reg;
        wen2_next = wen2_reg;
        sen1_next = sen1_reg;
        sen2_next = sen2_reg;
        d2_next = d2_reg;
        wdt_next = wdt_reg;
        restart_next = 1'b0;
        stop_next = 1'b0;
        wst_next = wst_reg;
        sst_next = sst_reg;
        if (wr) begin
            case (idx_reg)
                IDX_WAKE_EN1: wen1_next = CFG.wdata;
                IDX_WAKE_EN2: wen2_next = CFG.wdata;
                IDX_SMI_EN1: sen1_next = CFG.wdata;
                IDX_SMI_EN2: sen2_next = CFG.wdata;
                IDX_DELAY2: d2_next = (CFG.wdata > 8'(DELAY2_MAX))
                    ? DELAY2_MAX : CFG.wdata[5:0];
                IDX_SOFT_OFF: begin
                    wdt_next = CFG.wdata[WDT_LOW_W-1:0];
                    restart_next = CFG.wdata[RESTART_BIT];
                    stop_next = CFG.wdata[STOP_BIT];
                end
                default: ;
            endcase
        end
        // Status clears on read; a new event in that cycle wins
        if (rd && idx_reg == IDX_WAKE_ST1) begin
            wst_next[7:0] = 8'h00;
        end
        if (rd && idx_reg == IDX_WAKE_ST2) begin
            wst_next[NUM_WAKE-1:8] = '0;
        end
        if (rd && idx_reg == IDX_SMI_ST1) begin
            sst_next[7:0] = 8'h00;
        end
        if (rd && idx_reg == IDX_SMI_ST2) begin
            sst_next[NUM_SMI-1:8] = '0;
        end
        wst_next = wst_next | wake_fall;
        sst_next = sst_next | SMI_REQ;
        irq_n_next = !(sen2_reg[SMI_GATE_BIT]
            && |(SMI_REQ & smi_en));
    end

    // Button timers and power latch
    always_comb begin
        half_next = half_reg;
        ovr_next = ovr_reg;
        if (!pin_q_reg[NUM_WAKE]) begin
            half_next = 16'h0000;
            ovr_next = 4'h0;
        end else if (tick && ovr_reg != 4'(OVERRIDE_STEPS)) begin
            if (half_reg == 16'(HALF_SEC_TICKS - 1)) begin
                half_next = 16'h0000;
                ovr_next = ovr_reg + 4'h1;
            end else begin
                half_next = half_reg + 16'h0001;
            end
        end
        dly_run_next = dly_run_reg;
        dly_next = dly_reg;
        dhalf_next = dhalf_reg;
        if (btn_fall && on_reg && wen2_reg[OFF_EN_BIT]) begin
            dly_run_next = 1'b1;
            dly_next = 6'h00;
            dhalf_next = 16'h0000;
        end else if (dly_run_reg && tick) begin
            if (dhalf_reg == 16'(HALF_SEC_TICKS - 1)) begin
                dhalf_next = 16'h0000;
                dly_next = dly_reg + 6'h01;
                if (dly_reg == d2_reg) begin
                    dly_run_next = 1'b0;
                end
            end else begin
                dhalf_next = dhalf_reg + 16'h0001;
            end
        end
        if (!on_reg) begin
            dly_run_next = 1'b0;
        end
        on_next = on_reg;
        if (power_down) begin
            on_next = 1'b0;
        end else if (power_up) begin
            on_next = 1'b1;
        end
        ovr_sts_next = ovr_sts_reg && !OVERRIDE_STATUS_CLR;
        btn_sts_next = (btn_sts_reg && !BUTTON_STATUS_CLR) || btn_fall;
        if (ovr_fire) begin
            ovr_sts_next = 1'b1;
            btn_sts_next = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pin_q_reg <= PIN_IDLE;
            div_reg <= 11'h000;
            half_reg <= 16'h0000;
            ovr_reg <= 4'h0;
            dly_reg <= 6'h00;
            dly_run_reg <= 1'b0;
            dhalf_reg <= 16'h0000;
            on_reg <= 1'b0;
            ovr_sts_reg <= 1'b0;
            btn_sts_reg <= 1'b0;
            idx_reg <= 8'h00;
            wen1_reg <= WAKE_EN1_RST;
            wen2_reg <= WAKE_EN2_RST;
            wst_reg <= '0;
            sen1_reg <= SMI_EN_RST;
            sen2_reg <= SMI_EN_RST;
            sst_reg <= '0;
            d2_reg <= DELAY2_RST[5:0];
            wdt_reg <= '0;
            restart_reg <= 1'b0;
            stop_reg <= 1'b0;
            rdata_reg <= 8'h00;
            irq_n_reg <= 1'b1;
        end else begin
            pin_q_reg <= pin_q_next;
            div_reg <= div_next;
            half_reg <= half_next;
            ovr_reg <= ovr_next;
            dly_reg <= dly_next;
            dly_run_reg <= dly_run_next;
            dhalf_reg <= dhalf_next;
            on_reg <= on_next;
            ovr_sts_reg <= ovr_sts_next;
            btn_sts_reg <= btn_sts_next;
            idx_reg <= idx_next;
            wen1_reg <= wen1_next;
            wen2_reg <= wen2_next;
            wst_reg <= wst_next;
            sen1_reg <= sen1_next;
            sen2_reg <= sen2_next;
            sst_reg <= sst_next;
            d2_reg <= d2_next;
            wdt_reg <= wdt_next;
            restart_reg <= restart_next;
            stop_reg <= stop_next;
            rdata_reg <= rdata_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign CFG_RDATA = rdata_reg;
    assign POWER_ON_N = !on_reg;
    assign MGMT_IRQ_N = irq_n_reg;
    assign OVERRIDE_STATUS = ovr_sts_reg;
    assign BUTTON_PRESS_STATUS = btn_sts_reg;
    assign WDT_RESTART = restart_reg;
    assign WDT_STOP = stop_reg;
endmodule

// ===== tb/spm_chk.sv
`timescale 1ns/1ps
module spm_chk
    import spm_pkg::*;
#(
    parameter int HALF_SEC_TICKS = 16000
) (
    input wire logic CLK, // Clock
    input wire logic RST_N, // Reset
    input wire spm_pkg::spm_cfg_s CFG, // Access
    input wire logic CFG_MODE, // Config mode
    input wire logic [7:0] CFG_LDN, // Device
    input wire logic BTN, // Button
    input wire logic [spm_pkg::NUM_SMI-1:0] SMI_REQ, // Requests
    input wire logic OVERRIDE_ENABLE, // Override on
    input wire logic OVERRIDE_STATUS_CLR, // Clear
    input wire logic OVERRIDE_STATUS, // Override seen
    input wire logic BUTTON_PRESS_STATUS, // Press seen
    input wire logic POWER_ON_N, // Supply on
    input wire logic MGMT_IRQ_N, // SMI pin
    input wire logic WDT_RESTART, // Restart
    input wire logic WDT_STOP // Stop
);
    localparam int EARLY = (8 * HALF_SEC_TICKS - 1) * SLOW_TICK_CYC;
    localparam int LATE = (9 * HALF_SEC_TICKS + 1) * SLOW_TICK_CYC + 8;
    logic [7:0] idx_reg, idx_next, en1_reg, en1_next, en2_reg, en2_next;
    int hold_reg, hold_next;
    logic wr_ok, f4_wr, irq_calc;
    assign wr_ok = CFG.data_wr && (!CFG_MODE || CFG_LDN == PM_LDN);
    assign f4_wr = wr_ok && idx_reg == IDX_SOFT_OFF;
    assign irq_calc = en2_reg[7] && |(SMI_REQ & {en2_reg[4:0], en1_reg});
    // Shadow of the SMI enables and a raw button-held count
    always_comb begin
        idx_next = CFG.idx_wr ? CFG.wdata : idx_reg;
        en1_next = wr_ok && idx_reg == IDX_SMI_EN1 ? CFG.wdata : en1_reg;
        en2_next = wr_ok && idx_reg == IDX_SMI_EN2 ? CFG.wdata : en2_reg;
        hold_next = BTN ? hold_reg + 1 : 0;
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            idx_reg <= 8'h00;
            en1_reg <= 8'h00;
            en2_reg <= 8'h00;
            hold_reg <= 0;
        end else begin
            idx_reg <= idx_next;
            en1_reg <= en1_next;
            en2_reg <= en2_next;
            hold_reg <= hold_next;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_soft_off: assert property (
        f4_wr && CFG.wdata[SOFTWARE_POWER_OFF_BIT] |-> ##[1:2] POWER_ON_N)
        else $error("soft off missed");
    a_restart_pulse: assert property (
        f4_wr && CFG.wdata[RESTART_BIT] |-> ##[1:2] WDT_RESTART)
        else $error("restart pulse missed");
    a_stop_pulse: assert property (
        f4_wr && CFG.wdata[STOP_BIT] |-> ##[1:2] WDT_STOP)
        else $error("stop pulse missed");
    a_smi_gate: assert property (
        !en2_reg[SMI_GATE_BIT] |=> MGMT_IRQ_N)
        else $error("smi pin not gated");
    a_smi_equation: assert property (
        1'b1 |=> MGMT_IRQ_N == !$past(irq_calc))
        else $error("smi pin wrong");
    a_override_early: assert property (
        $rose(OVERRIDE_STATUS) |-> hold_reg >= EARLY)
        else $error("override too early");
    a_override_late: assert property (
        hold_reg == LATE && OVERRIDE_ENABLE |-> POWER_ON_N)
        else $error("override too late");
    a_override_gate: assert property (
        !OVERRIDE_ENABLE && !OVERRIDE_STATUS |=> !OVERRIDE_STATUS)
        else $error("override while disabled");
    a_override_effect: assert property (
        $rose(OVERRIDE_STATUS)
        |-> ##[0:2] (POWER_ON_N && !BUTTON_PRESS_STATUS))
        else $error("override effect missing");
    a_status_hold: assert property (
        OVERRIDE_STATUS && !OVERRIDE_STATUS_CLR
        && !$past(OVERRIDE_STATUS_CLR) |=> OVERRIDE_STATUS)
        else $error("override status lost");
    a_status_clear: assert property (
        OVERRIDE_STATUS_CLR |-> ##[1:2] !OVERRIDE_STATUS)
        else $error("override status kept");
    c_power_up: cover property ($fell(POWER_ON_N));
    c_override: cover property ($rose(OVERRIDE_STATUS));
    c_smi: cover property ($fell(MGMT_IRQ_N));
endmodule

bind spm_soft_power spm_chk #(.HALF_SEC_TICKS(HALF_SEC_TICKS)) u_chk (
    .CLK(CLK), .RST_N(RST_N), .CFG(CFG), .CFG_MODE(CFG_MODE),
    .CFG_LDN(CFG_LDN), .BTN(BTN), .SMI_REQ(SMI_REQ),
    .OVERRIDE_ENABLE(OVERRIDE_ENABLE),
    .OVERRIDE_STATUS_CLR(OVERRIDE_STATUS_CLR),
    .OVERRIDE_STATUS(OVERRIDE_STATUS),
    .BUTTON_PRESS_STATUS(BUTTON_PRESS_STATUS), .POWER_ON_N(POWER_ON_N),
    .MGMT_IRQ_N(MGMT_IRQ_N), .WDT_RESTART(WDT_RESTART),
    .WDT_STOP(WDT_STOP)
);

// ===== tb/spm_pwr_model.sv
`timescale 1ns/1ps
module spm_pwr_model (
    input wire logic CLK, // Clock
    input wire logic POWER_ON_N, // Supply request
    output logic BTN, // Button pin
    output logic PWR_GOOD // Supply up
);
    logic [3:0] ramp_reg, ramp_next;
    initial BTN = 1'b0;
    // Supply ramps up a few cycles after the request
    always_comb ramp_next = {ramp_reg[2:0], !POWER_ON_N};
    always_ff @(posedge CLK) ramp_reg <= ramp_next;
    assign PWR_GOOD = &ramp_reg;
    task automatic drive(input logic v, input int n);
        @(posedge CLK);
        BTN <= v;
        repeat (n) @(posedge CLK);
    endtask
endmodule

// ===== tb/spm_soft_power_tb_top.sv
`timescale 1ns/1ps
module spm_soft_power_tb_top;
    import spm_pkg::*;
    logic clk = 0, rst_n = 0, cfg_mode = 0, por = 1, a2_pass = 0;
    logic a2_rem = 0, por_wake = 0, ovr_en = 0, ovr_clr = 0, btn_clr = 0;
    logic ovr_sts, btn_sts, pon_n, irq_n, wdt_rst, wdt_stop, btn, pwr_good;
    logic [7:0] ldn = 8'h00, rdata;
    logic [15:0] en;
    logic [NUM_WAKE-1:0] wake = '1;
    logic [NUM_SMI-1:0] smi_req = '0;
    spm_cfg_s cfg = '0;
    int fails = 0, num_checks = 0, cycles = 0;
    spm_soft_power #(.HALF_SEC_TICKS(2)) dut (
        .CLK(clk), .RST_N(rst_n), .CFG(cfg), .CFG_MODE(cfg_mode),
        .CFG_LDN(ldn), .CFG_RDATA(rdata), .BTN(btn), .WAKE_SRC(wake),
        .TRICKLE_POR(por), .ALARM2_PASSED(a2_pass),
        .ALARM2_REMEMBER_EN(a2_rem), .TRICKLE_POR_WAKE_EN(por_wake),
        .OVERRIDE_ENABLE(ovr_en), .OVERRIDE_STATUS_CLR(ovr_clr),
        .BUTTON_STATUS_CLR(btn_clr), .SMI_REQ(smi_req),
        .OVERRIDE_STATUS(ovr_sts), .BUTTON_PRESS_STATUS(btn_sts),
        .POWER_ON_N(pon_n), .MGMT_IRQ_N(irq_n), .WDT_RESTART(wdt_rst),
        .WDT_STOP(wdt_stop)
    );
    spm_pwr_model pm (.CLK(clk), .POWER_ON_N(pon_n), .BTN(btn),
        .PWR_GOOD(pwr_good));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic put(logic [2:0] op, logic [7:0] d);
        @(posedge clk);
        cfg <= {op, d};
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        put(3'b100, a);
        put(3'b010, d);
        put(3'b000, 8'h00);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        put(3'b100, a);
        put(3'b001, 8'h00);
        put(3'b000, 8'h00);
        cyc(0);
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic wait_pon(logic v, int n);
        for (int k = 0; k < n && pon_n !== v; k++) cyc(0);
        chk("pon_n", v, pon_n);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(IDX_WAKE_EN1, 8'h00);
        rd(IDX_WAKE_EN2, 8'h80);
        rd(IDX_DELAY2, 8'h00);
        rd(8'hc0, 8'h00);
        wr(IDX_DELAY2, 8'h05);
        rd(IDX_DELAY2, 8'h05);
        @(posedge clk);
        cfg_mode <= 1'b1;
        ldn <= 8'h07;
        wr(IDX_DELAY2, 8'h00);
        ldn <= 8'h08;
        rd(IDX_DELAY2, 8'h05);
        @(posedge clk);
        cfg_mode <= 1'b0;
        wr(IDX_DELAY2, 8'h00);
        wr(IDX_SOFT_OFF, 8'h75);
        cyc(0);
        chk("wdt_rst", 1'b1, wdt_rst);
        chk("wdt_stop", 1'b1, wdt_stop);
        rd(IDX_SOFT_OFF, 8'h15);
        chk("wdt_rst", 1'b0, wdt_rst);
        chk("wdt_stop", 1'b0, wdt_stop);
        for (int i = 0; i < NUM_SMI; i++) begin
            en = 16'h8000 | (16'h0001 << i);
            wr(IDX_SMI_EN1, en[7:0]);
            wr(IDX_SMI_EN2, en[15:8]);
            smi_req <= ~(13'h0001 << i);
            cyc(3);
            chk("irq_n other", 1'b1, irq_n);
            @(posedge clk);
            smi_req <= 13'h0001 << i;
            cyc(3);
            chk("irq_n own", 1'b0, irq_n);
        end
        wr(IDX_SMI_EN2, 8'h10);
        cyc(3);
        chk("irq_n gated", 1'b1, irq_n);
        @(posedge clk);
        smi_req <= '0;
        wake[0] <= 1'b0;
        rd(IDX_SMI_ST1, 8'hff);
        rd(IDX_SMI_ST2, 8'h1f);
        cyc(1600);
        chk("pon_n", 1'b1, pon_n);
        rd(IDX_WAKE_ST1, 8'h01);
        rd(IDX_WAKE_ST1, 8'h00);
        wr(IDX_WAKE_EN1, 8'h02);
        wake[1] <= 1'b0;
        wait_pon(1'b0, 4000);
        @(posedge clk);
        wake <= '1;
        cyc(8);
        chk("pwr_good", 1'b1, pwr_good);
        wr(IDX_SOFT_OFF, 8'h80);
        cyc(2);
        chk("pon_n", 1'b1, pon_n);
        pm.drive(1'b1, 2000);
        pm.drive(1'b0, 1);
        wait_pon(1'b0, 4000);
        pm.drive(1'b1, 27000);
        cyc(0);
        chk("pon_n", 1'b0, pon_n);
        pm.drive(1'b0, 1);
        wait_pon(1'b1, 8000);
        chk("ovr_sts", 1'b0, ovr_sts);
        pm.drive(1'b1, 2000);
        pm.drive(1'b0, 1);
        wait_pon(1'b0, 4000);
        @(posedge clk);
        ovr_en <= 1'b1;
        pm.drive(1'b1, 1);
        wait_pon(1'b1, 30000);
        chk("ovr_sts", 1'b1, ovr_sts);
        chk("btn_sts", 1'b0, btn_sts);
        // Keep holding past the latest override point
        cyc(4800);
        chk("pon_n", 1'b1, pon_n);
        @(posedge clk);
        ovr_en <= 1'b0;
        pm.drive(1'b0, 1);
        wait_pon(1'b0, 4000);
        chk("ovr_sts", 1'b1, ovr_sts);
        @(posedge clk) ovr_clr <= 1'b1;
        @(posedge clk) ovr_clr <= 1'b0;
        cyc(2);
        chk("ovr_sts", 1'b0, ovr_sts);
        @(posedge clk) btn_clr <= 1'b1;
        @(posedge clk) btn_clr <= 1'b0;
        cyc(2);
        chk("btn_sts", 1'b0, btn_sts);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_SOFT_OFF, 8'h80);
            wait_pon(1'b1, 4);
            @(posedge clk);
            por_wake <= (i == 0);
            a2_rem <= (i != 0);
            a2_pass <= (i == 1);
            por <= 1'b0;
            cyc(1600);
            @(posedge clk);
            por <= 1'b1;
            if (i == 2) begin
                // Remember bit alone must not wake without a passed alarm
                cyc(1600);
                chk("pon_n", 1'b1, pon_n);
            end else begin
                wait_pon(1'b0, 4000);
            end
        end
        end_of_test();
    end
endmodule
